// [hdl/oss_step_sequencer.v]
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "oss_defs.vh"
module oss_step_sequencer (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Panel keys, asynchronous: start, stop, hold, branch
   input  wire [3:0]  panel_key,
   // Output setpoints
   output reg  [15:0] out_dc,
   output reg  [15:0] out_ac,
   output reg  [19:0] out_freq,
   output reg  [1:0]  out_wave_kind,
   output reg  [3:0]  out_arb_sel,
   output reg  [31:0] out_phase,
   output reg  [1:0]  step_sync,
   output reg  [1:0]  seq_state,
   output reg  [7:0]  seq_step
);
   localparam [9:0] TICK_CYC = `OSS_TICK_CYC;

   reg  [23:0] m_time [0:511];
   reg  [15:0] m_dc   [0:511];
   reg  [15:0] m_ac   [0:511];
   reg  [19:0] m_fr   [0:511];
   reg  [10:0] m_cfg  [0:511];
   reg  [27:0] m_jmp  [0:511];
   reg  [9:0]  jcnt   [0:511];

   reg         mode;
   reg  [1:0]  wave_kind;
   reg  [15:0] seq_len;
   reg  [8:0]  sel;
   reg  [3:0]  bus_cmd;
   reg         aw_h;
   reg         w_h;
   reg  [7:0]  wa;
   reg  [31:0] wd;
   reg  [3:0]  ws;
   reg  [2:0]  ks1, ks2, ks3, ks4;
   reg  [3:0]  key_lvl;
   reg  [9:0]  pre;
   reg  [23:0] el;
   reg         held_term;
   reg  [15:0] st_dc, st_ac;
   reg  [19:0] st_fr;
   reg  [32:0] ph_sum;
   reg         ph_wrap;

   wire [3:0]  s2 = {ks4[1], ks3[1], ks2[1], ks1[1]};
   wire [3:0]  s3 = {ks4[2], ks3[2], ks2[2], ks1[2]};
   wire [3:0]  key_pulse = s2 & s3 & ~key_lvl;
   wire [3:0]  cmd = bus_cmd | key_pulse;
   wire        tick = (pre == TICK_CYC - 10'h001);
   wire        fire = aw_h & w_h & ~s_axi_bvalid;
   wire [8:0]  ci = {mode, seq_step};
   wire [8:0]  c0 = {mode, 8'h00};
   wire [1:0]  optype = m_cfg[ci][7:6];
   wire [1:0]  term = m_cfg[ci][10:9];
   wire [7:0]  jt = m_jmp[ci][7:0];
   wire [9:0]  jc = m_jmp[ci][17:8];
   wire [7:0]  bt = m_jmp[ci][27:20];
   wire [7:0]  len = mode ? seq_len[15:8] : seq_len[7:0];
   wire [23:0] tlen = (m_time[ci] == 24'h000000) ? 24'h000001 : m_time[ci];
   wire        stop_wr = (seq_state != `OSS_ST_IDLE) && cmd[`OSS_C_STOP];
   wire        keep = (optype == `OSS_OP_KEEP);
   wire [15:0] tg_dc = keep ? st_dc : m_dc[ci];
   wire [15:0] tg_ac = keep ? st_ac : m_ac[ci];
   wire [19:0] tg_fr = keep ? st_fr : m_fr[ci];
   wire [23:0] el1 = el + 24'h000001;

   // Reads one register image; bit 32 flags a mapped address.
   function [32:0] rmux;
      input [7:0] a;
      begin
         case (a)
            `OSS_A_CTRL:   rmux = {1'b1, 27'h0, mode, 4'h0};
            `OSS_A_STATUS: rmux = {1'b1, 14'h0, step_sync, seq_step, 3'h0, held_term, 2'h0, seq_state};
            `OSS_A_SEL:    rmux = {1'b1, 23'h0, sel};
            `OSS_A_TIME:   rmux = {1'b1, 8'h0, m_time[sel]};
            `OSS_A_DC:     rmux = {1'b1, 16'h0, m_dc[sel]};
            `OSS_A_AC:     rmux = {1'b1, 16'h0, m_ac[sel]};
            `OSS_A_FREQ:   rmux = {1'b1, 12'h0, m_fr[sel]};
            `OSS_A_CFG:    rmux = {1'b1, 21'h0, m_cfg[sel]};
            `OSS_A_JUMP:   rmux = {1'b1, 4'h0, m_jmp[sel]};
            `OSS_A_WAVE:   rmux = {1'b1, 30'h0, wave_kind};
            `OSS_A_LEN:    rmux = {1'b1, 16'h0, seq_len};
            default:       rmux = 33'h0;
         endcase
      end
   endfunction

   wire [32:0] wr_old = rmux(wa);
   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire [31:0] wm = (wr_old[31:0] & ~wmask) | (wd & wmask);
   wire [9:0]  wjc = (wm[17:8] > `OSS_MAX_JUMPS) ? `OSS_MAX_JUMPS : wm[17:8];

   function [19:0] interp;
      input [20:0] s;
      input [20:0] t;
      input [23:0] e;
      input [23:0] d;
      reg signed [46:0] p;
      begin
         p = $signed({{26{t[20]}}, t}) - $signed({{26{s[20]}}, s});
         p = p * $signed({23'h0, e});
         p = p / $signed({23'h0, d});
         interp = s[19:0] + p[19:0];
      end
   endfunction

   // The DC setpoint is signed, so its sweep end points are sign extended.
   wire [19:0] sw_dc = interp({{5{st_dc[15]}}, st_dc}, {{5{tg_dc[15]}}, tg_dc}, el1, tlen);
   wire [19:0] sw_ac = interp({5'h0, st_ac}, {5'h0, tg_ac}, el1, tlen);
   wire [19:0] sw_fr = interp({1'b0, st_fr}, {1'b0, tg_fr}, el1, tlen);

   // Step transition at step end or on start from a terminating hold.
   reg        nx_idle;
   reg [7:0]  nx_step;
   reg        j_inc;
   reg        j_zero;
   always @* begin
      nx_idle = 1'b0;
      nx_step = seq_step + 8'h01;
      j_inc = 1'b0;
      j_zero = 1'b0;
      if (jt != 8'h00 && (jc == 10'h000 || jcnt[ci] < jc)) begin
         nx_step = jt;
         j_inc = (jc != 10'h000);
      end else begin
         j_zero = (jt != 8'h00);
         if (seq_step >= len || seq_step == 8'hff) begin
            nx_idle = 1'b1;
         end
      end
   end

   wire       is_run = (seq_state == `OSS_ST_RUN);
   wire       step_end = is_run && tick && !cmd[`OSS_C_STOP] && !cmd[`OSS_C_HOLD]
                         && !(cmd[`OSS_C_BRANCH] && bt != 8'h00)
                         && el1 >= tlen && (!m_cfg[ci][8] || ph_wrap);
   wire       adv_hold = (seq_state == `OSS_ST_HOLD) && held_term
                         && cmd[`OSS_C_START] && !cmd[`OSS_C_STOP];
   wire       advance = (step_end && term == `OSS_TM_CONTINUE_ACTION) || adv_hold;
   wire       j_clr = (seq_state == `OSS_ST_IDLE) && cmd[`OSS_C_START];

   genvar g;
   generate
      for (g = 0; g < 512; g = g + 1) begin : g_entry
         always @(posedge aclk) begin
            if (!aresetn || j_clr) begin
               jcnt[g] <= 10'h000;
            end else if (advance && ci == g && j_inc) begin
               jcnt[g] <= jcnt[g] + 10'h001;
            end else if (advance && ci == g && j_zero) begin
               jcnt[g] <= 10'h000;
            end
         end
         always @(posedge aclk) begin
            if (!aresetn) begin
               m_time[g] <= 24'h000001;
               m_dc[g]   <= 16'h0000;
               m_ac[g]   <= 16'h0000;
               m_fr[g]   <= 20'h00000;
               m_cfg[g]  <= 11'h000;
               m_jmp[g]  <= 28'h0000000;
            end else if (stop_wr && c0 == g) begin
               m_dc[g] <= out_dc;
               m_ac[g] <= out_ac;
               m_fr[g] <= out_freq;
               m_cfg[g] <= {m_cfg[g][10:4], out_arb_sel};
            end else if (fire && sel == g) begin
               case (wa)
                  `OSS_A_TIME: m_time[g] <= (wm[23:0] > `OSS_MAX_TICKS) ? `OSS_MAX_TICKS : wm[23:0];
                  `OSS_A_DC:   m_dc[g] <= wm[15:0];
                  `OSS_A_AC:   m_ac[g] <= wm[15:0];
                  `OSS_A_FREQ: m_fr[g] <= wm[19:0];
                  `OSS_A_CFG:  m_cfg[g] <= wm[10:0];
                  `OSS_A_JUMP: m_jmp[g] <= {wm[27:20], 2'h0, wjc, wm[7:0]};
                  default:     m_cfg[g] <= m_cfg[g];
               endcase
            end
         end
      end
      for (g = 0; g < 4; g = g + 1) begin : g_key
         always @(posedge aclk) begin
            if (!aresetn) begin
               key_lvl[g] <= 1'b0;
            end else if (s2[g] == s3[g]) begin
               key_lvl[g] <= s2[g];
            end
         end
      end
   endgenerate

   // Three-stage key synchronisers.
   always @(posedge aclk) begin
      if (!aresetn) begin
         ks1 <= 3'h0;
         ks2 <= 3'h0;
         ks3 <= 3'h0;
         ks4 <= 3'h0;
      end else begin
         ks1 <= {ks1[1:0], panel_key[0]};
         ks2 <= {ks2[1:0], panel_key[1]};
         ks3 <= {ks3[1:0], panel_key[2]};
         ks4 <= {ks4[1:0], panel_key[3]};
      end
   end

   // AXI4-Lite slave and control registers.
   wire next_aw_h = fire ? 1'b0 : (aw_h | (s_axi_awvalid & s_axi_awready));
   wire next_w_h = fire ? 1'b0 : (w_h | (s_axi_wvalid & s_axi_wready));
   wire next_bv = fire | (s_axi_bvalid & ~s_axi_bready);
   wire ar_go = s_axi_arvalid & s_axi_arready;
   wire next_rv = ar_go | (s_axi_rvalid & ~s_axi_rready);
   wire [32:0] rd = rmux(s_axi_araddr);
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_h <= 1'b0;
         w_h <= 1'b0;
         wa <= 8'h00;
         wd <= 32'h00000000;
         ws <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OSS_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `OSS_RESP_OKAY;
         mode <= 1'b0;
         wave_kind <= `OSS_WK_SINE;
         seq_len <= 16'h0101;
         sel <= 9'h000;
         bus_cmd <= 4'h0;
      end else begin
         aw_h <= next_aw_h;
         w_h <= next_w_h;
         s_axi_bvalid <= next_bv;
         s_axi_awready <= ~next_aw_h & ~next_bv;
         s_axi_wready <= ~next_w_h & ~next_bv;
         s_axi_rvalid <= next_rv;
         s_axi_arready <= ~next_rv;
         bus_cmd <= 4'h0;
         if (s_axi_awvalid && s_axi_awready) begin
            wa <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd <= s_axi_wdata;
            ws <= s_axi_wstrb;
         end
         if (ar_go) begin
            s_axi_rdata <= rd[31:0];
            s_axi_rresp <= rd[32] ? `OSS_RESP_OKAY : `OSS_RESP_SLVERR;
         end
         if (fire) begin
            s_axi_bresp <= wr_old[32] ? `OSS_RESP_OKAY : `OSS_RESP_SLVERR;
            case (wa)
               `OSS_A_CTRL: begin
                  bus_cmd <= wm[3:0];
                  if (seq_state == `OSS_ST_IDLE) begin
                     mode <= wm[`OSS_C_MODE];
                  end
               end
               `OSS_A_SEL: sel <= wm[8:0];
               `OSS_A_WAVE: if (seq_state == `OSS_ST_IDLE) begin
                  wave_kind <= wm[1:0];
               end
               `OSS_A_LEN: seq_len <= wm[15:0];
               default: sel <= sel;
            endcase
         end
      end
   end

   always @* begin
      ph_sum = {1'b0, out_phase} + {1'b0, out_freq[19:0] * `OSS_PHASE_MUL};
      ph_wrap = ph_sum[32];
   end

   // Sequencer proper.
   always @(posedge aclk) begin
      if (!aresetn) begin
         seq_state <= `OSS_ST_IDLE;
         seq_step <= 8'h00;
         pre <= 10'h000;
         el <= 24'h000000;
         held_term <= 1'b0;
         st_dc <= 16'h0000;
         st_ac <= 16'h0000;
         st_fr <= 20'h00000;
         out_dc <= 16'h0000;
         out_ac <= 16'h0000;
         out_freq <= 20'h00000;
         out_wave_kind <= `OSS_WK_SINE;
         out_arb_sel <= 4'h0;
         out_phase <= 32'h00000000;
         step_sync <= 2'h0;
      end else begin
         pre <= tick ? 10'h000 : pre + 10'h001;
         if (tick) begin
            out_phase <= ph_sum[31:0];
         end
         out_wave_kind <= wave_kind;
         case (seq_state)
            `OSS_ST_IDLE: begin
               out_dc <= m_dc[c0];
               out_ac <= m_ac[c0];
               out_freq <= m_fr[c0];
               out_arb_sel <= m_cfg[c0][3:0];
               step_sync <= 2'h0;
               held_term <= 1'b0;
               if (cmd[`OSS_C_START]) begin
                  seq_state <= `OSS_ST_RUN;
                  seq_step <= 8'h01;
                  el <= 24'h000000;
                  st_dc <= m_dc[c0];
                  st_ac <= m_ac[c0];
                  st_fr <= m_fr[c0];
               end
            end
            `OSS_ST_RUN: begin
               step_sync <= m_cfg[ci][5:4];
               if (cmd[`OSS_C_STOP]) begin
                  seq_state <= `OSS_ST_IDLE;
                  seq_step <= 8'h00;
                  step_sync <= 2'h0;
               end else if (cmd[`OSS_C_HOLD]) begin
                  seq_state <= `OSS_ST_HOLD;
                  held_term <= 1'b0;
               end else if (cmd[`OSS_C_BRANCH] && bt != 8'h00) begin
                  seq_step <= bt;
                  el <= 24'h000000;
                  st_dc <= out_dc;
                  st_ac <= out_ac;
                  st_fr <= out_freq;
               end else if (tick) begin
                  el <= (el1 >= tlen) ? tlen : el1;
                  if (optype == `OSS_OP_SWEEP) begin
                     out_dc <= sw_dc[15:0];
                     out_ac <= sw_ac[15:0];
                     out_freq <= sw_fr;
                  end else begin
                     out_dc <= tg_dc;
                     out_ac <= tg_ac;
                     out_freq <= tg_fr;
                  end
                  if (wave_kind == `OSS_WK_ARB && !keep) begin
                     out_arb_sel <= m_cfg[ci][3:0];
                  end
                  if (step_end) begin
                     if (term == `OSS_TM_HOLD) begin
                        seq_state <= `OSS_ST_HOLD;
                        held_term <= 1'b1;
                     end else if (term == `OSS_TM_STOP) begin
                        seq_state <= `OSS_ST_IDLE;
                        seq_step <= 8'h00;
                        step_sync <= 2'h0;
                     end else if (nx_idle) begin
                        seq_state <= `OSS_ST_IDLE;
                        seq_step <= 8'h00;
                        step_sync <= 2'h0;
                     end else begin
                        seq_step <= nx_step;
                        el <= 24'h000000;
                        st_dc <= tg_dc;
                        st_ac <= tg_ac;
                        st_fr <= tg_fr;
                     end
                  end
               end
            end
            `OSS_ST_HOLD: begin
               if (cmd[`OSS_C_STOP]) begin
                  seq_state <= `OSS_ST_IDLE;
                  seq_step <= 8'h00;
                  step_sync <= 2'h0;
               end else if (adv_hold) begin
                  seq_state <= nx_idle ? `OSS_ST_IDLE : `OSS_ST_RUN;
                  seq_step <= nx_idle ? 8'h00 : nx_step;
                  step_sync <= nx_idle ? 2'h0 : step_sync;
                  el <= 24'h000000;
                  st_dc <= out_dc;
                  st_ac <= out_ac;
                  st_fr <= out_freq;
                  held_term <= 1'b0;
               end else if (cmd[`OSS_C_START]) begin
                  seq_state <= `OSS_ST_RUN;
               end
            end
            default: seq_state <= `OSS_ST_IDLE;
         endcase
      end
   end
endmodule // oss_step_sequencer
`default_nettype wire

// [hdl/oss_defs.vh]
`ifndef OSS_DEFS_VH
`define OSS_DEFS_VH
`define OSS_CLK_NS      100
`define OSS_TICK_NS     100000
`define OSS_TICK_CYC    10'h3e8
`define OSS_MAX_JUMPS   10'h3e7
`define OSS_MAX_TICKS   24'h98967f
`define OSS_NSTEP       255
`define OSS_A_CTRL      8'h00
`define OSS_A_STATUS    8'h04
`define OSS_A_SEL       8'h08
`define OSS_A_TIME      8'h0c
`define OSS_A_DC        8'h10
`define OSS_A_AC        8'h14
`define OSS_A_FREQ      8'h18
`define OSS_A_CFG       8'h1c
`define OSS_A_JUMP      8'h20
`define OSS_A_WAVE      8'h24
`define OSS_A_LEN       8'h28
`define OSS_C_START     0
`define OSS_C_STOP      1
`define OSS_C_HOLD      2
`define OSS_C_BRANCH    3
`define OSS_C_MODE      4
`define OSS_ST_IDLE     2'h0
`define OSS_ST_RUN      2'h1
`define OSS_ST_HOLD     2'h2
`define OSS_OP_CONST    2'h0
`define OSS_OP_SWEEP    2'h1
`define OSS_OP_KEEP     2'h2
`define OSS_TM_CONTINUE_ACTION     2'h0
`define OSS_TM_HOLD     2'h1
`define OSS_TM_STOP     2'h2
`define OSS_WK_SINE     2'h0
`define OSS_WK_SQUARE   2'h1
`define OSS_WK_ARB      2'h2
`define OSS_PHASE_MUL   32'h0000a7c6
`define OSS_RESP_OKAY   2'h0
`define OSS_RESP_SLVERR 2'h2
`endif

// [tb/oss_seq_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "oss_defs.vh"
module oss_seq_asserts (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Sequencer outputs
   input wire logic [15:0] out_dc,
   input wire logic [1:0]  step_sync,
   input wire logic [1:0]  seq_state,
   input wire logic [7:0]  seq_step
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sync_idle_a: assert property (seq_state == `OSS_ST_IDLE |-> step_sync == 2'h0)
      else $error("step sync not false while idle");
   idle_step_a: assert property (seq_state == `OSS_ST_IDLE |-> seq_step == 8'h00)
      else $error("idle without regular output step");
   run_step_a: assert property (seq_state != `OSS_ST_IDLE |-> seq_step != 8'h00)
      else $error("sequence active on step zero");
   state_legal_a: assert property (seq_state != 2'h3)
      else $error("illegal sequencer state");
   hold_freeze_a: assert property ((seq_state == `OSS_ST_HOLD && $stable(seq_state)) |-> $stable(out_dc))
      else $error("output moved during hold");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response late");
   bresp_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   rdata_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");

   cover property (seq_state == `OSS_ST_RUN);
   cover property (seq_state == `OSS_ST_HOLD);
   cover property (seq_state == `OSS_ST_RUN && $changed(seq_step));
endmodule // oss_seq_asserts

bind oss_step_sequencer oss_seq_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .out_dc, .step_sync, .seq_state, .seq_step);
`default_nettype wire

// [tb/oss_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module oss_panel_model (
   // Clock
   input wire logic       aclk,
   // Keys to the sequencer
   output var logic [3:0] panel_key
);
   initial panel_key = 4'h0;

   // Panel control press
   // A key is held long enough for the three-stage synchroniser to see one clean edge.
   task automatic press(input int k);
      @(posedge aclk);
      panel_key[k] <= 1'b1;
      repeat (8) @(posedge aclk);
      panel_key[k] <= 1'b0;
   endtask
endmodule // oss_panel_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "oss_defs.vh"
module tb;
   logic        aclk, aresetn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, p;
   logic [3:0]  s_axi_wstrb, panel_key;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, out_wave_kind, step_sync, seq_state;
   logic [15:0] out_dc, out_ac;
   logic [19:0] out_freq;
   logic [3:0]  out_arb_sel;
   logic [31:0] out_phase;
   logic [7:0]  seq_step;
   int          fail_count, checks_done, cycles;

   oss_step_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .panel_key,
      .out_dc, .out_ac, .out_freq, .out_wave_kind, .out_arb_sel, .out_phase, .step_sync, .seq_state, .seq_step);
   oss_panel_model PANEL (.aclk, .panel_key);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask

   task automatic wait_for(input logic [1:0] st, input logic [7:0] sp);
      int n;
      n = 0;
      while (!(seq_state === st && seq_step === sp) && n < 20000) begin
         @(posedge aclk);
         n++;
      end
      chk({22'h0, seq_state, seq_step}, {22'h0, st, sp});
   endtask

   task automatic results;
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         results();
      end
   end

   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf; aresetn = 1'b0; fail_count = 0; checks_done = 0; cycles = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values and an unmapped address.
      rd(`OSS_A_STATUS, `OSS_RESP_OKAY, d); chk(d, 32'h0);
      rd(`OSS_A_TIME, `OSS_RESP_OKAY, d); chk(d, 32'h1);
      rd(8'h2c, `OSS_RESP_SLVERR, d); chk(d, 32'h0);
      wr(8'h2c, 32'h1, `OSS_RESP_SLVERR);
      $display("test reset done");
      // Step 1 constant, branch to 2; step 2 ends in hold.
      wr(`OSS_A_SEL, 32'h0, `OSS_RESP_OKAY); wr(`OSS_A_DC, 32'h55, `OSS_RESP_OKAY);
      wr(`OSS_A_SEL, 32'h1, `OSS_RESP_OKAY); wr(`OSS_A_TIME, 32'h14, `OSS_RESP_OKAY);
      wr(`OSS_A_DC, 32'h100, `OSS_RESP_OKAY); wr(`OSS_A_CFG, 32'h10, `OSS_RESP_OKAY);
      wr(`OSS_A_JUMP, 32'h00200000, `OSS_RESP_OKAY);
      wr(`OSS_A_SEL, 32'h2, `OSS_RESP_OKAY); wr(`OSS_A_TIME, 32'h3, `OSS_RESP_OKAY);
      wr(`OSS_A_DC, 32'h200, `OSS_RESP_OKAY); wr(`OSS_A_CFG, 32'h220, `OSS_RESP_OKAY);
      wr(`OSS_A_LEN, 32'h0102, `OSS_RESP_OKAY);
      rd(`OSS_A_TIME, `OSS_RESP_OKAY, d); chk(d, 32'h3);
      chk({16'h0, out_dc}, 32'h55);
      $display("test program done");
      // Run, hold, resume.
      wr(`OSS_A_CTRL, 32'h1, `OSS_RESP_OKAY);
      wait_for(`OSS_ST_RUN, 8'h1);
      repeat (1100) @(posedge aclk);
      chk({16'h0, out_dc}, 32'h100);
      chk({30'h0, step_sync}, 32'h1);
      wr(`OSS_A_CTRL, 32'h4, `OSS_RESP_OKAY);
      wait_for(`OSS_ST_HOLD, 8'h1);
      repeat (2000) @(posedge aclk);
      chk({16'h0, out_dc}, 32'h100);
      chk({24'h0, seq_step}, 32'h1);
      wr(`OSS_A_CTRL, 32'h1, `OSS_RESP_OKAY);
      wait_for(`OSS_ST_RUN, 8'h1);
      $display("test hold done");
      // Branch from the panel, termination hold, then panel stop.
      PANEL.press(3);
      wait_for(`OSS_ST_RUN, 8'h2);
      wait_for(`OSS_ST_HOLD, 8'h2);
      chk({16'h0, out_dc}, 32'h200);
      chk({30'h0, step_sync}, 32'h2);
      PANEL.press(1);
      wait_for(`OSS_ST_IDLE, 8'h0);
      repeat (20) @(posedge aclk);
      chk({16'h0, out_dc}, 32'h200);
      chk({30'h0, step_sync}, 32'h0);
      rd(`OSS_A_STATUS, `OSS_RESP_OKAY, d); chk({22'h0, d[15:8], d[1:0]}, 32'h0);
      $display("test branch done");
      // A fresh start always enters step 1.
      wr(`OSS_A_CTRL, 32'h1, `OSS_RESP_OKAY);
      wait_for(`OSS_ST_RUN, 8'h1);
      wr(`OSS_A_CTRL, 32'h2, `OSS_RESP_OKAY);
      wait_for(`OSS_ST_IDLE, 8'h0);
      $display("test restart done");
      // Current-mode sequence: sweep step, keep step, one jump back, then the end.
      wr(`OSS_A_CTRL, 32'h10, `OSS_RESP_OKAY);
      wr(`OSS_A_WAVE, 32'h2, `OSS_RESP_OKAY);
      wr(`OSS_A_SEL, 32'h100, `OSS_RESP_OKAY);
      wr(`OSS_A_FREQ, 32'h2710, `OSS_RESP_OKAY);
      wr(`OSS_A_SEL, 32'h101, `OSS_RESP_OKAY);
      wr(`OSS_A_TIME, 32'h4, `OSS_RESP_OKAY);
      wr(`OSS_A_AC, 32'h40, `OSS_RESP_OKAY);
      wr(`OSS_A_FREQ, 32'h2710, `OSS_RESP_OKAY);
      wr(`OSS_A_CFG, 32'h45, `OSS_RESP_OKAY);
      wr(`OSS_A_SEL, 32'h102, `OSS_RESP_OKAY);
      wr(`OSS_A_TIME, 32'h2, `OSS_RESP_OKAY);
      wr(`OSS_A_AC, 32'h7ff, `OSS_RESP_OKAY);
      wr(`OSS_A_CFG, 32'h89, `OSS_RESP_OKAY);
      wr(`OSS_A_JUMP, 32'h101, `OSS_RESP_OKAY);
      wr(`OSS_A_LEN, 32'h0202, `OSS_RESP_OKAY);
      rd(`OSS_A_CTRL, `OSS_RESP_OKAY, d);
      chk(d, 32'h10);
      chk({30'h0, out_wave_kind}, 32'h2);
      wr(`OSS_A_CTRL, 32'h11, `OSS_RESP_OKAY);
      wait_for(`OSS_ST_RUN, 8'h1);
      while (out_ac === 16'h0) @(posedge aclk);
      chk({16'h0, out_ac}, 32'h10);
      p = out_phase;
      wait_for(`OSS_ST_RUN, 8'h2);
      chk({16'h0, out_ac}, 32'h40);
      repeat (1000) @(posedge aclk);
      chk(out_phase, p + 32'h4 * 32'h2710 * `OSS_PHASE_MUL);
      chk({16'h0, out_ac}, 32'h40);
      chk({12'h0, out_freq}, 32'h2710);
      chk({28'h0, out_arb_sel}, 32'h5);
      wait_for(`OSS_ST_RUN, 8'h1);
      wait_for(`OSS_ST_RUN, 8'h2);
      wait_for(`OSS_ST_IDLE, 8'h0);
      $display("test loop done");
      results();
   end
endmodule // tb
`default_nettype wire
